// *** hdl/adc_channel_power_control.sv ***
// Operation
// - after power-up the first analog input, code zero, is selected.
// - leaving any power-down keeps the channel that was selected before.
// - channel code k selects analog input k plus one, binary decode.
// - reference enabled when reference-disable bit is 0, disabled when 1.
// - mode 00 keeps the device fully powered regardless of logic inputs.
// - mode 01 powers everything down, keeps control bits until mode changes.
// - mode 10 enters full shutdown after every conversion; wake takes 5 us.
// - auto modes power down on sixteenth rising clock edge after select falls.
// - auto modes start power-up on first falling clock edge after select falls.
// - leaving shutdown: mode 00 powers up at the sixteenth rising edge, mode 10 or 11 at the next frame's first falling edge.
// - wake from standby or with external reference takes about 1 us.
// - wake from shutdown takes about 5 us.
// - at first power-up the device is fully powered in normal mode.
// - first eight clock cycles of a frame load the control register.
// - device stays powered only if both mode bits were written zero.
// - select falling starts a frame; sample on the second rising edge.
// - after select rises a new frame may start at once.
// - control word: ignored bit7, zero bit6, channel 5:3, ref 2, mode 1:0.
// - result is four leading zeros then twelve bits, msb first.
// - the serial clock moves data and also clocks the conversion.
`timescale 1ns/1ns
`default_nettype none

module adc_channel_power_control #(
    parameter int RESULT_W = adc_ctrl_pkg::RESULT_W
) (
    // system clock and reset
    input  wire logic                      clk_sys,
    input  wire logic                      rst,
    // serial link from the host
    input  wire logic                      sclk,
    input  wire logic                      cs_n,
    input  wire logic                      din,
    output logic                           dout_o,
    output logic                           dout_oe,
    // analog core
    input  wire logic                      cmp_hi,
    output adc_ctrl_pkg::analog_ctl_t      analog_ctl,
    // status in the system clock domain
    output adc_ctrl_pkg::ctrl_word_t       ctrl_status,
    output logic                           core_powered,
    output logic                           core_ready,
    output logic                           ctrl_updated
);

    // frame state is cleared whenever select is high
    logic frame_rst;
    assign frame_rst = rst | cs_n;

    // ---------------- serial clock domain, rising edges ----------------
    logic [adc_ctrl_pkg::CNT_W-1:0] edge_cnt_q, edge_cnt_d;
    logic [adc_ctrl_pkg::CTRL_BITS-1:0] shift_q, shift_d;
    logic [RESULT_W-1:0]            sar_q, sar_d;
    logic                           hold_q, hold_d;
    logic                           last_edge;

    // edge counter saturates at the frame length
    assign last_edge = (edge_cnt_q == adc_ctrl_pkg::CNT_W'(adc_ctrl_pkg::FRAME_EDGES - 1));

    function automatic logic [RESULT_W-1:0] sar_step(input logic [RESULT_W-1:0] cur,
                                                     input int bit_idx,
                                                     input logic keep);
        logic [RESULT_W-1:0] nxt;
        nxt = cur;
        nxt[bit_idx] = keep;
        if (bit_idx > 0) begin
            nxt[bit_idx-1] = 1'b1;
        end
        return nxt;
    endfunction

    always_comb begin
        int pos;
        pos        = 0;
        edge_cnt_d = edge_cnt_q;
        shift_d    = shift_q;
        sar_d      = sar_q;
        hold_d     = hold_q;
        if (edge_cnt_q != adc_ctrl_pkg::CNT_W'(adc_ctrl_pkg::FRAME_EDGES)) begin
            edge_cnt_d = edge_cnt_q + 1'b1;
        end
        if (edge_cnt_q < adc_ctrl_pkg::CNT_W'(adc_ctrl_pkg::CTRL_BITS)) begin
            shift_d = {shift_q[adc_ctrl_pkg::CTRL_BITS-2:0], din};
        end
        if (edge_cnt_q == adc_ctrl_pkg::CNT_W'(adc_ctrl_pkg::SAMPLE_EDGE - 1)) begin
            hold_d = 1'b1;
            sar_d  = {1'b1, {(RESULT_W-1){1'b0}}};
        end
        // conversion clocked by sclk, one bit per edge
        if (edge_cnt_q >= adc_ctrl_pkg::CNT_W'(adc_ctrl_pkg::LEAD_ZEROS - 1) &&
            edge_cnt_q <  adc_ctrl_pkg::CNT_W'(adc_ctrl_pkg::LEAD_ZEROS - 1 + RESULT_W)) begin
            pos   = RESULT_W - 1 - (int'(edge_cnt_q) - (adc_ctrl_pkg::LEAD_ZEROS - 1));
            sar_d = sar_step(sar_q, pos, cmp_hi);
        end
    end

    always_ff @(posedge sclk or posedge frame_rst) begin
        if (frame_rst) begin
            edge_cnt_q <= '0;
            shift_q    <= '0;
            sar_q      <= '0;
            hold_q     <= 1'b0;
        end else begin
            edge_cnt_q <= edge_cnt_d;
            shift_q    <= shift_d;
            sar_q      <= sar_d;
            hold_q     <= hold_d;
        end
    end

    // control register survives frames and power-down, reset only at power-up
    // control word fields
    adc_ctrl_pkg::ctrl_word_t ctrl_q, ctrl_d;
    logic                     upd_tgl_q, upd_tgl_d;

    always_comb begin
        ctrl_d    = ctrl_q;
        upd_tgl_d = upd_tgl_q;
        // new bits take effect on the sixteenth edge
        if (!cs_n && last_edge) begin
            ctrl_d    = adc_ctrl_pkg::ctrl_word_t'(shift_q);
            upd_tgl_d = ~upd_tgl_q;
        end
    end

    // normal mode, channel zero at power-up
    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            ctrl_q    <= adc_ctrl_pkg::CTRL_RESET;
            upd_tgl_q <= 1'b0;
        end else begin
            ctrl_q    <= ctrl_d;
            upd_tgl_q <= upd_tgl_d;
        end
    end

    // ---------------- serial clock domain, falling edges ----------------
    logic                           awake_q, awake_d;
    logic                           dout_q, dout_d;
    logic [adc_ctrl_pkg::CNT_W-1:0] out_idx;

    assign out_idx = adc_ctrl_pkg::CNT_W'(adc_ctrl_pkg::LEAD_ZEROS + RESULT_W - 1) - edge_cnt_q;

    always_comb begin
        // first falling edge wakes the core
        awake_d = 1'b1;
        dout_d  = 1'b0;
        // four zeros then result msb first
        if (edge_cnt_q >= adc_ctrl_pkg::CNT_W'(adc_ctrl_pkg::LEAD_ZEROS) &&
            edge_cnt_q <  adc_ctrl_pkg::CNT_W'(adc_ctrl_pkg::FRAME_EDGES)) begin
            dout_d = sar_q[out_idx[3:0]];
        end
    end

    always_ff @(negedge sclk or posedge frame_rst) begin
        if (frame_rst) begin
            awake_q <= 1'b0;
            dout_q  <= 1'b0;
        end else begin
            awake_q <= awake_d;
            dout_q  <= dout_d;
        end
    end

    // ---------------- power decisions ----------------
    adc_ctrl_pkg::power_mode_t mode;
    logic                      core_on;
    logic                      ref_on;
    logic                      frame_done;

    assign mode       = adc_ctrl_pkg::power_mode_t'({ctrl_q.power_mode_hi, ctrl_q.power_mode_lo});
    assign frame_done = (edge_cnt_q == adc_ctrl_pkg::CNT_W'(adc_ctrl_pkg::FRAME_EDGES));

    always_comb begin
        core_on = 1'b1;
        ref_on  = 1'b1;
        unique case (mode)
            // only both bits zero keeps power
            adc_ctrl_pkg::PM_NORMAL: begin
                core_on = 1'b1;
                ref_on  = 1'b1;
            end
            adc_ctrl_pkg::PM_SHUTDOWN: begin
                core_on = 1'b0;
                ref_on  = 1'b0;
            end
            // down at frame end, reference too
            adc_ctrl_pkg::PM_AUTO_SHUT: begin
                core_on = awake_q && !frame_done;
                ref_on  = core_on;
            end
            adc_ctrl_pkg::PM_AUTO_STBY: begin
                core_on = awake_q && !frame_done;
                ref_on  = 1'b1;
            end
        endcase
    end

    // channel code drives the mux directly, held through power-down
    // reference gated by the disable bit
    assign analog_ctl.core_on        = core_on;
    assign analog_ctl.ref_on         = ref_on && !ctrl_q.ref_disable;
    assign analog_ctl.hold           = hold_q;
    assign analog_ctl.channel_select = ctrl_q.channel_select;
    assign analog_ctl.trial_code     = sar_q;

    // output released when select rises, next frame may start at once
    assign dout_o  = dout_q;
    assign dout_oe = !cs_n;

    // ---------------- system clock domain ----------------
    logic [1:0] core_sync_q, ref_sync_q, tgl_sync_q;
    logic       tgl_seen_q;
    adc_ctrl_pkg::ctrl_word_t ctrl_sys_q, ctrl_sys_d;
    logic       upd_q, upd_d;

    always_comb begin
        ctrl_sys_d = ctrl_sys_q;
        upd_d      = 1'b0;
        if (tgl_sync_q[1] != tgl_seen_q) begin
            ctrl_sys_d = ctrl_q;
            upd_d      = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            core_sync_q <= '0;
            ref_sync_q  <= '0;
            tgl_sync_q  <= '0;
            tgl_seen_q  <= 1'b0;
            ctrl_sys_q  <= adc_ctrl_pkg::CTRL_RESET;
            upd_q       <= 1'b0;
        end else begin
            core_sync_q <= {core_sync_q[0], analog_ctl.core_on};
            ref_sync_q  <= {ref_sync_q[0], analog_ctl.ref_on};
            tgl_sync_q  <= {tgl_sync_q[0], upd_tgl_q};
            tgl_seen_q  <= tgl_sync_q[1];
            ctrl_sys_q  <= ctrl_sys_d;
            upd_q       <= upd_d;
        end
    end

    // wake timer: long wake when the enabled reference was down as well
    logic [adc_ctrl_pkg::WAKE_CNT_W-1:0] wake_cnt_q, wake_cnt_d;
    logic                                long_q, long_d;
    logic                                ready_q, ready_d;
    logic [adc_ctrl_pkg::WAKE_CNT_W-1:0] wake_target;

    assign wake_target = long_q ? adc_ctrl_pkg::WAKE_CNT_W'(adc_ctrl_pkg::WAKE_SHUT_CYC)
                                : adc_ctrl_pkg::WAKE_CNT_W'(adc_ctrl_pkg::WAKE_STBY_CYC);

    always_comb begin
        wake_cnt_d = wake_cnt_q;
        long_d     = long_q;
        ready_d    = ready_q;
        if (!core_sync_q[1]) begin
            wake_cnt_d = '0;
            ready_d    = 1'b0;
            long_d     = !ref_sync_q[1] && !ctrl_sys_q.ref_disable;
        end else if (!ready_q) begin
            wake_cnt_d = wake_cnt_q + 1'b1;
            ready_d    = (wake_cnt_q + 1'b1) >= wake_target;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wake_cnt_q <= '0;
            long_q     <= 1'b1;
            ready_q    <= 1'b0;
        end else begin
            wake_cnt_q <= wake_cnt_d;
            long_q     <= long_d;
            ready_q    <= ready_d;
        end
    end

    assign ctrl_status  = ctrl_sys_q;
    assign core_powered = core_sync_q[1];
    assign core_ready   = ready_q;
    assign ctrl_updated = upd_q;

    // ---------------- assertions ----------------
    a_sample_on_second: assert property (@(posedge sclk) disable iff (frame_rst)
        (edge_cnt_q == 5'd2) |-> hold_q)
        else $error("hold not set after second rising edge");

    a_track_before_two: assert property (@(posedge sclk) disable iff (frame_rst)
        (edge_cnt_q < 5'd2) |-> !hold_q)
        else $error("hold set too early");

    // the next rising edge is in the following frame, so only power-up reset disables it
    a_ctrl_load_end: assert property (@(posedge sclk) disable iff (rst)
        (edge_cnt_q == 5'h0f && !cs_n) |=> (ctrl_q == $past(shift_q)))
        else $error("control word not taken on sixteenth edge");

    a_ctrl_kept: assert property (@(posedge sclk) disable iff (rst)
        (!last_edge || cs_n) |=> $stable(ctrl_q))
        else $error("control word changed outside frame end");

    a_stby_ref_on: assert property (@(posedge sclk) disable iff (rst)
        (mode == adc_ctrl_pkg::PM_AUTO_STBY && !ctrl_q.ref_disable) |-> analog_ctl.ref_on)
        else $error("reference dropped in standby");

    a_normal_powered: assert property (@(posedge sclk) disable iff (rst)
        (mode == adc_ctrl_pkg::PM_NORMAL) |-> analog_ctl.core_on)
        else $error("normal mode lost power");

    a_shutdown_off: assert property (@(posedge sclk) disable iff (rst)
        (mode == adc_ctrl_pkg::PM_SHUTDOWN) |-> !analog_ctl.core_on && !analog_ctl.ref_on)
        else $error("shutdown left circuitry on");

    // sclk stands still after the last edge, so the system clock watches the gap
    a_auto_down_end: assert property (@(posedge clk_sys) disable iff (rst)
        (frame_done && ctrl_q.power_mode_hi) |-> !analog_ctl.core_on)
        else $error("auto mode still powered after frame");

    a_ref_follows_bit: assert property (@(posedge sclk) disable iff (rst)
        ctrl_q.ref_disable |-> !analog_ctl.ref_on)
        else $error("reference on while disabled");

    a_lead_zeros: assert property (@(negedge sclk) disable iff (frame_rst)
        (edge_cnt_q < 5'd4) |=> !dout_q)
        else $error("leading zero missing");

    a_wake_short: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(core_sync_q[1]) && !long_q |-> !core_ready ##19 !core_ready ##1 core_ready)
        else $error("short wake time wrong");

    a_wake_long_cnt: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(core_ready) |-> wake_cnt_q == (long_q ? 8'd100 : 8'd20))
        else $error("wake count mismatch");

endmodule // adc_channel_power_control

`default_nettype wire

// *** hdl/adc_ctrl_pkg.sv ***
package adc_ctrl_pkg;

    // control word layout, sent msb first during the first edges of a frame
    typedef struct packed {
        logic       ignored_bit;
        logic       zero_bit;
        logic [2:0] channel_select;
        logic       ref_disable;
        logic       power_mode_hi;
        logic       power_mode_lo;
    } ctrl_word_t;

    typedef enum logic [1:0] {
        PM_NORMAL    = 2'h0,
        PM_SHUTDOWN  = 2'h1,
        PM_AUTO_SHUT = 2'h2,
        PM_AUTO_STBY = 2'h3
    } power_mode_t;

    // analog-facing controls, all in the serial clock domain
    typedef struct packed {
        logic        core_on;
        logic        ref_on;
        logic        hold;
        logic [2:0]  channel_select;
        logic [11:0] trial_code;
    } analog_ctl_t;

    localparam ctrl_word_t CTRL_RESET   = 8'h00;
    localparam int         CTRL_BITS    = 8;
    localparam int         FRAME_EDGES  = 16;
    localparam int         SAMPLE_EDGE  = 2;
    localparam int         LEAD_ZEROS   = 4;
    localparam int         RESULT_W     = 12;
    localparam int         CNT_W        = 5;

    // time constants
    localparam int CLK_PERIOD_NS   = 50;
    localparam int T_WAKE_SHUT_NS  = 5000;
    localparam int T_WAKE_STBY_NS  = 1000;
    localparam int WAKE_SHUT_CYC   = (T_WAKE_SHUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_STBY_CYC   = (T_WAKE_STBY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_CNT_W      = 8;

endpackage

// *** test/adc_host_model.sv ***
`timescale 1ns/1ns
`default_nettype none

module adc_host_model #(
    parameter int HALF_NS = 80
) (
    // serial link
    output logic        sclk,
    output logic        cs_n,
    output logic        din,
    input  wire logic   dout_o,
    // received result
    output logic [15:0] rx_word,
    output logic        rx_done
);

    initial begin
        sclk    = 1'b1;
        cs_n    = 1'b1;
        din     = 1'b0;
        rx_word = 16'h0000;
        rx_done = 1'b0;
    end

    // one transfer; fewer than sixteen edges cuts it short
    task automatic frame(input logic [7:0] word, input int edges, input int gap_ns,
                         input bit report);
        logic [15:0] rx;
        rx   = 16'h0000;
        cs_n = 1'b0;
        #(HALF_NS);
        for (int m = 1; m <= edges; m++) begin
            sclk = 1'b0;
            din = (m <= 8) ? word[8-m] : ~din;
            if (m == 1) #(gap_ns);
            #(HALF_NS);
            sclk = 1'b1;
            rx   = {rx[14:0], dout_o};
            #(HALF_NS);
        end
        // link clock stands still, data line no longer holds its value
        cs_n = 1'b1;
        din  = ~din;
        if (report && edges == 16) begin
            rx_word = rx;
            rx_done = 1'b1;
            #1;
            rx_done = 1'b0;
        end
        #(HALF_NS);
    endtask

endmodule // adc_host_model

`default_nettype wire

// *** test/adc_channel_power_control_tb.sv ***
`timescale 1ns/1ns
`default_nettype none

module adc_channel_power_control_tb;

    logic                      clk_sys;
    logic                      rst;
    logic                      sclk;
    logic                      cs_n;
    logic                      din;
    logic                      dout_o;
    logic                      dout_oe;
    logic                      cmp_hi;
    adc_ctrl_pkg::analog_ctl_t analog_ctl;
    adc_ctrl_pkg::ctrl_word_t  ctrl_status;
    logic                      core_powered;
    logic                      core_ready;
    logic                      ctrl_updated;
    logic [15:0]               rx_word;
    logic                      rx_done;
    logic [11:0]               vin;
    logic [15:0]               exp_q[$];
    int                        failures = 0;
    int                        n_compared = 0;
    int                        n_upd = 0;
    int                        seed = 60912;

    // ideal comparator: the approximation settles on vin
    assign cmp_hi = (vin >= analog_ctl.trial_code);

    adc_channel_power_control i_adc_channel_power_control (
        .clk_sys(clk_sys), .rst(rst), .sclk(sclk), .cs_n(cs_n), .din(din),
        .dout_o(dout_o), .dout_oe(dout_oe), .cmp_hi(cmp_hi), .analog_ctl(analog_ctl),
        .ctrl_status(ctrl_status), .core_powered(core_powered),
        .core_ready(core_ready), .ctrl_updated(ctrl_updated)
    );

    adc_host_model i_adc_host_model (
        .sclk(sclk), .cs_n(cs_n), .din(din), .dout_o(dout_o),
        .rx_word(rx_word), .rx_done(rx_done)
    );

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    always @(posedge rx_done) begin
        if (exp_q.size() == 0)
            check(1, 0, "unexpected result");
        else
            check(rx_word, exp_q.pop_front(), "result word");
    end

    always @(posedge clk_sys) begin
        if (ctrl_updated === 1'b1)
            n_upd <= n_upd + 1;
    end

    // full transfer with a random sample value, then wait for the status copy
    task automatic xfer(input logic [2:0] ch, input logic refd, input logic [1:0] pm,
                        input int gap_ns, input bit report);
        adc_ctrl_pkg::ctrl_word_t w;
        int                       n0;
        int                       k;
        int                       r;
        r = $random(seed);
        w = adc_ctrl_pkg::CTRL_RESET;
        w.ignored_bit    = r[0];
        w.channel_select = ch;
        w.ref_disable    = refd;
        {w.power_mode_hi, w.power_mode_lo} = pm;
        @(posedge clk_sys);
        vin <= r[12:1];
        @(posedge clk_sys);
        if (report)
            exp_q.push_back({4'h0, vin});
        n0 = n_upd;
        i_adc_host_model.frame(w, 16, gap_ns, report);
        check(dout_oe, 0, "pin released");
        k = 0;
        while (n_upd == n0 && k < 40) begin
            @(posedge clk_sys);
            k++;
        end
        check(k < 40, 1, "status update");
        if (k >= 40)
            tally_and_finish();
        check(ctrl_status, w, "status word");
    endtask

    initial begin
        #3_000_000;
        failures++;
        $display("[FAIL] %0t run timed out", $time);
        tally_and_finish();
    end

    initial begin
        int k;
        rst = 1'b1;
        vin = 12'h000;
        repeat (2) @(posedge clk_sys);
        check(ctrl_status, 8'h00, "reset word");
        check(analog_ctl.core_on & analog_ctl.ref_on, 1, "powered in reset");
        rst <= 1'b0;
        k = 0;
        // look between edges so the ready flop has settled
        while (core_ready !== 1'b1 && k < 300) begin
            @(negedge clk_sys);
            k++;
        end
        check(k > 100 && k < 110, 1, "wake time after reset");
        if (k >= 300)
            tally_and_finish();
        $display("test reset done");

        for (int c = 0; c < 8; c++) begin
            xfer(c[2:0], 1'b0, 2'h0, 0, 1'b1);
            check(analog_ctl.channel_select, c[2:0], "mux address");
            check(analog_ctl.core_on, 1, "stays powered");
        end
        $display("test channels done");

        xfer(3'h5, 1'b1, 2'h0, 0, 1'b1);
        check(analog_ctl.ref_on, 0, "reference off");
        xfer(3'h5, 1'b0, 2'h0, 0, 1'b1);
        check(analog_ctl.ref_on, 1, "reference on");
        $display("test reference done");

        xfer(3'h6, 1'b0, 2'h1, 0, 1'b0);
        check(analog_ctl.core_on | analog_ctl.ref_on, 0, "full shutdown");
        k = n_upd;
        i_adc_host_model.frame(8'h00, 8, 0, 1'b0);
        repeat (40) @(posedge clk_sys);
        check(n_upd == k, 1, "short frame ignored");
        check(core_powered | analog_ctl.core_on, 0, "still shut down");
        check(analog_ctl.channel_select, 3'h6, "channel kept");
        xfer(3'h6, 1'b0, 2'h0, 0, 1'b0);
        check(analog_ctl.core_on, 1, "normal mode wakes");
        $display("test shutdown done");

        for (int i = 0; i < 2; i++) begin
            xfer(3'h1, 1'b0, i ? 2'h2 : 2'h3, 0, 1'b1);
            check(analog_ctl.core_on, 0, "auto power down");
            check(analog_ctl.ref_on, i ? 0 : 1, "reference in sleep");
            fork
                xfer(3'h1, 1'b0, i ? 2'h2 : 2'h3, i ? 5200 : 0, 1'b1);
                begin
                    @(negedge sclk);
                    #5;
                    check(analog_ctl.core_on, 1, "wake on first fall");
                    check(dout_oe, 1, "pin driven");
                end
            join
        end
        xfer(3'h0, 1'b0, 2'h0, 0, 1'b1);
        check(analog_ctl.core_on, 1, "back to normal");
        $display("test auto modes done");
        repeat (4) @(posedge clk_sys);
        check(exp_q.size(), 0, "all results seen");
        tally_and_finish();
    end

endmodule // adc_channel_power_control_tb

`default_nettype wire
